//--- pkg/eqf_pkg.sv
// Package for the error queue with entry filter
`default_nettype none
package eqf_pkg;

  // ---------------------------------------------------------------
  // Sizes and fixed codes
  // ---------------------------------------------------------------
  localparam int CODE_W = 16;
  localparam int DEPTH = 10;
  localparam int PTR_W = 4;
  localparam int FLT_N = 1024;
  localparam int FLT_W = 10;
  localparam logic signed [CODE_W-1:0] CODE_MIN = -16'sd512;
  localparam logic signed [CODE_W-1:0] CODE_MAX = 16'sd511;
  localparam logic signed [CODE_W-1:0] STATUS_LO = 16'sd100;
  localparam logic signed [CODE_W-1:0] OVF_CODE = 16'sd350;
  localparam logic signed [CODE_W-1:0] NO_ERR_CODE = 16'sd0;
  localparam logic [PTR_W-1:0] LAST_PTR = 4'h9;
  localparam logic [PTR_W-1:0] DEPTH_CNT = 4'hA;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] ENA_RST = 16'h0000;

  // Power-up filter: codes below the status class are admitted
  function automatic logic [FLT_N-1:0] flt_reset();
    logic [FLT_N-1:0] v;
    v = '0;
    for (int i = 0; i < FLT_N; i++) begin
      v[i] = (int'(CODE_MIN) + i) < int'(STATUS_LO);
    end
    return v;
  endfunction
  localparam logic [FLT_N-1:0] FLT_RST = flt_reset();

  // ---------------------------------------------------------------
  // Host commands
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ENA_START,
    CMD_ENA_ADD,
    CMD_DIS_ADD,
    CMD_CLEAR,
    CMD_PRESET,
    CMD_WR_ENA
  } eqf_cmd_op_t;

  typedef enum logic [1:0] {
    SEL_MEAS,
    SEL_QUES,
    SEL_OPER
  } eqf_ena_sel_t;

  typedef struct packed {
    eqf_cmd_op_t op;
    logic signed [CODE_W-1:0] first;
    logic signed [CODE_W-1:0] last;
    eqf_ena_sel_t sel;
    logic [15:0] data;
  } eqf_cmd_t;

  typedef struct packed {
    logic valid;
    logic signed [CODE_W-1:0] code;
  } eqf_msg_t;

  typedef struct packed {
    logic [15:0] meas;
    logic [15:0] ques;
    logic [15:0] oper;
  } eqf_ena_t;

  typedef struct packed {
    logic [DEPTH-1:0][CODE_W-1:0] slot;
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] count;
    logic [FLT_N-1:0] filter;
    eqf_msg_t rd;
    logic qry_en;
    eqf_ena_t ena;
  } eqf_state_t;

endpackage
`default_nettype wire

//--- verilog/eqf_queue.sv
// Error queue with per-code entry filter and status enable preset
//
// How it works
// - FIFO holds at most ten messages
// - Read returns oldest entry and removes it
// - Filling last slot stores overflow code 350
// - Empty queue reads back code 0
// - Queue empty after reset
// - Codes are signed sixteen bit values
// - Clear command empties the queue but keeps a message admitted in the same cycle
// - Reset filter admits errors, blocks status codes
// - Enable list disables all, then enables listed
// - Disabled codes other than overflow code 350 never enter the queue
// - Disable list blocks the listed codes
// - Filter bits can be queried per code
// - Lists given as single codes or ranges
// - Empty enable list blocks every code
// - Preset clears the three enable registers
// - Preset touches no other register
// - Both read sources pop the same queue
`default_nettype none
module eqf_queue (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Messages raised by the instrument
  input wire eqf_pkg::eqf_msg_t i_msg,
  // Queue reads from the two command branches
  input wire logic i_rd_stat,
  input wire logic i_rd_sys,
  // Host commands
  input wire eqf_pkg::eqf_cmd_t i_cmd,
  // Filter query
  input wire logic signed [eqf_pkg::CODE_W-1:0] i_qry_code,
  // Read answer
  output logic o_rd_valid,
  output logic signed [eqf_pkg::CODE_W-1:0] o_rd_code,
  // Queue and filter state
  output logic [eqf_pkg::PTR_W-1:0] o_count,
  output logic o_qry_en,
  // Event enable registers
  output eqf_pkg::eqf_ena_t o_ena
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Code lies inside the filtered window
  function automatic logic code_in_win(input logic signed [eqf_pkg::CODE_W-1:0] c);
    return (c >= eqf_pkg::CODE_MIN) && (c <= eqf_pkg::CODE_MAX);
  endfunction

  // Filter index of an in-window code
  function automatic logic [eqf_pkg::FLT_W-1:0] code_idx(
    input logic signed [eqf_pkg::CODE_W-1:0] c);
    logic signed [eqf_pkg::CODE_W-1:0] d;
    d = c - eqf_pkg::CODE_MIN;
    return d[eqf_pkg::FLT_W-1:0];
  endfunction

  // Slot pointer plus offset, wrapping at the depth
  function automatic logic [eqf_pkg::PTR_W-1:0] ptr_add(
    input logic [eqf_pkg::PTR_W-1:0] p, input logic [eqf_pkg::PTR_W-1:0] n);
    logic [eqf_pkg::PTR_W:0] s;
    s = {1'b0, p} + {1'b0, n};
    if (s >= {1'b0, eqf_pkg::DEPTH_CNT}) begin
      s = s - {1'b0, eqf_pkg::DEPTH_CNT};
    end
    return s[eqf_pkg::PTR_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  eqf_pkg::eqf_state_t st;
  eqf_pkg::eqf_state_t next_st;

  logic pop_req;
  logic signed [eqf_pkg::CODE_W-1:0] range_lo;
  logic signed [eqf_pkg::CODE_W-1:0] range_hi;
  logic msg_admit;
  logic [eqf_pkg::PTR_W-1:0] live;
  logic [eqf_pkg::PTR_W-1:0] wr_ptr;

  // Either branch pops the one queue
  assign pop_req = i_rd_stat | i_rd_sys;

  // Range endpoints in either order, single code as equal ends
  assign range_lo = (i_cmd.first <= i_cmd.last) ? i_cmd.first : i_cmd.last;
  assign range_hi = (i_cmd.first <= i_cmd.last) ? i_cmd.last : i_cmd.first;

  // Filter looked up only as a message arrives
  assign msg_admit = i_msg.valid && code_in_win(i_msg.code) &&
                     st.filter[code_idx(i_msg.code)];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rd.valid = 1'b0;
    live = st.count;
    // Host commands
    case (i_cmd.op)
      eqf_pkg::CMD_ENA_START: begin
        next_st.filter = '0;
      end
      eqf_pkg::CMD_ENA_ADD: begin
        for (int i = 0; i < eqf_pkg::FLT_N; i++) begin
          if ((int'(eqf_pkg::CODE_MIN) + i >= int'(range_lo)) &&
              (int'(eqf_pkg::CODE_MIN) + i <= int'(range_hi))) begin
            next_st.filter[i] = 1'b1;
          end
        end
      end
      eqf_pkg::CMD_DIS_ADD: begin
        for (int i = 0; i < eqf_pkg::FLT_N; i++) begin
          if ((int'(eqf_pkg::CODE_MIN) + i >= int'(range_lo)) &&
              (int'(eqf_pkg::CODE_MIN) + i <= int'(range_hi))) begin
            next_st.filter[i] = 1'b0;
          end
        end
      end
      eqf_pkg::CMD_CLEAR: begin
        live = '0;
      end
      eqf_pkg::CMD_PRESET: begin
        next_st.ena.meas = eqf_pkg::ENA_RST;
        next_st.ena.ques = eqf_pkg::ENA_RST;
        next_st.ena.oper = eqf_pkg::ENA_RST;
      end
      eqf_pkg::CMD_WR_ENA: begin
        case (i_cmd.sel)
          eqf_pkg::SEL_MEAS: next_st.ena.meas = i_cmd.data;
          eqf_pkg::SEL_QUES: next_st.ena.ques = i_cmd.data;
          eqf_pkg::SEL_OPER: next_st.ena.oper = i_cmd.data;
          default: next_st.ena = st.ena;
        endcase
      end
      default: begin
        next_st.filter = st.filter;
      end
    endcase
    // Read: oldest entry, or the no-error code when empty
    if (pop_req) begin
      next_st.rd.valid = 1'b1;
      if (live != '0) begin
        next_st.rd.code = st.slot[st.head];
        next_st.head = ptr_add(st.head, 4'h1);
        live = live - 4'h1;
      end else begin
        next_st.rd.code = eqf_pkg::NO_ERR_CODE;
      end
    end
    // Write behind the live entries; last slot takes overflow
    wr_ptr = ptr_add(next_st.head, live);
    if (msg_admit) begin
      if (live < eqf_pkg::LAST_PTR) begin
        next_st.slot[wr_ptr] = i_msg.code;
        live = live + 4'h1;
      end else if (live == eqf_pkg::LAST_PTR) begin
        next_st.slot[wr_ptr] = eqf_pkg::OVF_CODE;
        live = live + 4'h1;
      end
    end
    next_st.count = live;
    // Filter query answer
    next_st.qry_en = code_in_win(i_qry_code) && st.filter[code_idx(i_qry_code)];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st.slot <= '0;
      st.head <= '0;
      st.count <= '0;
      st.filter <= eqf_pkg::FLT_RST;
      st.rd <= '0;
      st.qry_en <= 1'b0;
      st.ena <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from the state register
  assign o_rd_valid = st.rd.valid;
  assign o_rd_code = st.rd.code;
  assign o_count = st.count;
  assign o_qry_en = st.qry_en;
  assign o_ena = st.ena;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  logic [eqf_pkg::FLT_N-1:0] chk_flt;
  assign chk_flt = st.filter;

  property p_depth_limit;
    st.count <= eqf_pkg::DEPTH_CNT;
  endproperty
  a_depth_limit: assert property (p_depth_limit)
    else $error("queue count above ten");

  property p_oldest_read;
    (pop_req && st.count != '0 && i_cmd.op != eqf_pkg::CMD_CLEAR) |=>
      (o_rd_valid && o_rd_code == $past(st.slot[st.head]));
  endproperty
  a_oldest_read: assert property (p_oldest_read)
    else $error("read did not return the oldest entry");

  property p_pop_shrinks;
    (pop_req && st.count != '0 && !msg_admit && i_cmd.op != eqf_pkg::CMD_CLEAR) |=>
      (st.count == $past(st.count) - 4'h1);
  endproperty
  a_pop_shrinks: assert property (p_pop_shrinks)
    else $error("read did not remove the entry");

  property p_overflow_slot;
    (msg_admit && !pop_req && st.count == eqf_pkg::LAST_PTR &&
     i_cmd.op != eqf_pkg::CMD_CLEAR) |=>
      (st.count == eqf_pkg::DEPTH_CNT &&
       st.slot[ptr_add(st.head, eqf_pkg::LAST_PTR)] == eqf_pkg::OVF_CODE);
  endproperty
  a_overflow_slot: assert property (p_overflow_slot)
    else $error("last slot does not hold the overflow code");

  property p_empty_read;
    (pop_req && (st.count == '0 || i_cmd.op == eqf_pkg::CMD_CLEAR)) |=>
      (o_rd_valid && o_rd_code == eqf_pkg::NO_ERR_CODE);
  endproperty
  a_empty_read: assert property (p_empty_read)
    else $error("empty read did not give the no-error code");

  property p_clear_empties;
    (i_cmd.op == eqf_pkg::CMD_CLEAR) |=> (st.count <= 4'h1);
  endproperty
  a_clear_empties: assert property (p_clear_empties)
    else $error("clear left messages in the queue");

  property p_blocked_msg;
    (i_msg.valid && !msg_admit && !pop_req && i_cmd.op != eqf_pkg::CMD_CLEAR) |=>
      $stable(st.count);
  endproperty
  a_blocked_msg: assert property (p_blocked_msg)
    else $error("disabled message entered the queue");

  property p_enable_start;
    (i_cmd.op == eqf_pkg::CMD_ENA_START) |=> (chk_flt == '0);
  endproperty
  a_enable_start: assert property (p_enable_start)
    else $error("enable list did not first block every code");

  property p_preset_clears;
    (i_cmd.op == eqf_pkg::CMD_PRESET) |=> (o_ena == '0 && $stable(chk_flt));
  endproperty
  a_preset_clears: assert property (p_preset_clears)
    else $error("preset did not clear the enable registers");

  property p_dual_read;
    (i_rd_sys && !i_rd_stat) |=> o_rd_valid;
  endproperty
  a_dual_read: assert property (p_dual_read)
    else $error("system branch read gave no answer");

  property p_full_drop;
    (msg_admit && !pop_req && st.count == eqf_pkg::DEPTH_CNT &&
     i_cmd.op != eqf_pkg::CMD_CLEAR) |=> ($stable(st.count) && $stable(st.slot));
  endproperty
  a_full_drop: assert property (p_full_drop)
    else $error("full queue took another message");

  property p_admit_grows;
    (msg_admit && !pop_req && st.count < eqf_pkg::LAST_PTR &&
     i_cmd.op != eqf_pkg::CMD_CLEAR) |=>
      (st.count == $past(st.count) + 4'h1 &&
       st.slot[ptr_add(st.head, $past(st.count))] == $past(i_msg.code));
  endproperty
  a_admit_grows: assert property (p_admit_grows)
    else $error("admitted message was not stored behind the others");

  property p_enable_item;
    (i_cmd.op == eqf_pkg::CMD_ENA_ADD && code_in_win(i_cmd.first)) |=>
      chk_flt[$past(code_idx(i_cmd.first))];
  endproperty
  a_enable_item: assert property (p_enable_item)
    else $error("listed code was not enabled");

  property p_disable_item;
    (i_cmd.op == eqf_pkg::CMD_DIS_ADD && code_in_win(i_cmd.last)) |=>
      !chk_flt[$past(code_idx(i_cmd.last))];
  endproperty
  a_disable_item: assert property (p_disable_item)
    else $error("listed code was not disabled");

  property p_filter_keeps_queue;
    ((i_cmd.op == eqf_pkg::CMD_ENA_START || i_cmd.op == eqf_pkg::CMD_ENA_ADD ||
      i_cmd.op == eqf_pkg::CMD_DIS_ADD) && !pop_req && !i_msg.valid) |=>
      ($stable(st.count) && $stable(st.slot) && $stable(st.head));
  endproperty
  a_filter_keeps_queue: assert property (p_filter_keeps_queue)
    else $error("filter change altered stored messages");

  property p_preset_keeps_queue;
    (i_cmd.op == eqf_pkg::CMD_PRESET && !pop_req && !i_msg.valid) |=>
      ($stable(st.count) && $stable(st.slot) && $stable(st.head));
  endproperty
  a_preset_keeps_queue: assert property (p_preset_keeps_queue)
    else $error("preset altered the queue");

  property p_clear_exact;
    (i_cmd.op == eqf_pkg::CMD_CLEAR && !i_msg.valid) |=> (st.count == '0);
  endproperty
  a_clear_exact: assert property (p_clear_exact)
    else $error("clear without a message left entries");

  property p_answer_once;
    !pop_req |=> !o_rd_valid;
  endproperty
  a_answer_once: assert property (p_answer_once)
    else $error("read answer without a read");

  property p_sys_pop;
    (i_rd_sys && !i_rd_stat && st.count != '0 && !i_msg.valid &&
     i_cmd.op != eqf_pkg::CMD_CLEAR) |=>
      (st.count == $past(st.count) - 4'h1 && o_rd_code == $past(st.slot[st.head]));
  endproperty
  a_sys_pop: assert property (p_sys_pop)
    else $error("system branch read did not pop the queue");

  property p_empty_stays;
    (pop_req && st.count == '0 && !i_msg.valid) |=> (st.count == '0);
  endproperty
  a_empty_stays: assert property (p_empty_stays)
    else $error("read of an empty queue changed the count");

endmodule // eqf_queue
`default_nettype wire

//--- testbench/eqf_host.sv
// Host-side model issuing queue reads and status commands
`default_nettype none
module eqf_host (
  // Clock
  input wire logic i_clk,
  // Read strobes toward the queue
  output logic o_rd_stat,
  output logic o_rd_sys,
  // Command toward the queue
  output eqf_pkg::eqf_cmd_t o_cmd,
  // Read answer from the queue
  input wire logic i_rd_valid,
  input wire logic signed [15:0] i_rd_code
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    o_rd_stat = 1'b0;
    o_rd_sys = 1'b0;
    o_cmd = '0;
  end

  // One command for one cycle; a list item is a range or a single code
  task automatic cmd(input eqf_pkg::eqf_cmd_op_t op, input int a, input int b,
                     input eqf_pkg::eqf_ena_sel_t s, input logic [15:0] d);
    o_cmd = '{op, 16'(a), 16'(b), s, d};
    @(posedge i_clk);
    #10;
    o_cmd.op = eqf_pkg::CMD_NONE;
    @(posedge i_clk);
    #10;
  endtask

  // One read pulse on either branch, answer taken the cycle after
  task automatic rd(input bit sys, output logic v, output logic signed [15:0] c);
    o_rd_stat = !sys;
    o_rd_sys = sys;
    @(posedge i_clk);
    #10;
    o_rd_stat = 1'b0;
    o_rd_sys = 1'b0;
    v = i_rd_valid;
    c = i_rd_code;
    @(posedge i_clk);
    #10;
  endtask
endmodule // eqf_host
`default_nettype wire

//--- testbench/test_error_queue_with_filter.sv
// Self-checking testbench for the error queue with entry filter
`default_nettype none
module test_error_queue_with_filter;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  eqf_pkg::eqf_msg_t i_msg = '0;
  logic signed [15:0] i_qry_code = '0;
  logic rd_stat, rd_sys, rd_valid, qry_en, v;
  logic signed [15:0] rd_code, c;
  logic [3:0] count;
  eqf_pkg::eqf_cmd_t cmd;
  eqf_pkg::eqf_ena_t ena;
  int num_errors = 0;
  int cmp_count = 0;
  int lfsr = 68966;
  logic signed [15:0] q[$];
  bit flt[1024];
  logic [15:0] ed[3];
  int pts[8] = '{-110, -222, -223, -230, -229, -109, 150, -1};

  // 10 MHz clock
  always #50 i_clk = ~i_clk;

  eqf_queue i_eqf_queue (.i_clk(i_clk), .i_rstn(i_rstn), .i_msg(i_msg), .i_rd_stat(rd_stat),
    .i_rd_sys(rd_sys), .i_cmd(cmd), .i_qry_code(i_qry_code), .o_rd_valid(rd_valid),
    .o_rd_code(rd_code), .o_count(count), .o_qry_en(qry_en), .o_ena(ena));
  eqf_host i_eqf_host (.i_clk(i_clk), .o_rd_stat(rd_stat), .o_rd_sys(rd_sys), .o_cmd(cmd),
    .i_rd_valid(rd_valid), .i_rd_code(rd_code));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk_v(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_b(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  // Galois shift register, value 0..m-1
  function automatic int rnd(input int m);
    lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'hA300_0000 : 32'h0000_0000);
    return (lfsr & 32'h7FFF_FFFF) % m;
  endfunction
  task automatic tick();
    @(posedge i_clk);
    #10;
  endtask
  task automatic rng(input int a, input int b, input bit val);
    for (int i = a; i <= b; i++) flt[i + 512] = val;
  endtask
  task automatic hc(input eqf_pkg::eqf_cmd_op_t op, input int a, input int b);
    i_eqf_host.cmd(op, a, b, eqf_pkg::SEL_MEAS, 16'h0000);
  endtask
  // Raise a message and follow it in the model queue
  task automatic msg(input int cd);
    i_msg = '{1'b1, 16'(cd)};
    tick();
    i_msg.valid = 1'b0;
    if (flt[cd + 512]) begin
      if (q.size() < 9) q.push_back(16'(cd));
      else if (q.size() == 9) q.push_back(16'sd350);
    end
    chk_v("count", 16'(q.size()), 16'(count));
    tick();
  endtask
  task automatic pop(input bit sys);
    logic signed [15:0] e;
    e = q.size() ? q.pop_front() : 16'sd0;
    i_eqf_host.rd(sys, v, c);
    chk_b("rd_valid", 1'b1, v);
    chk_v("rd_code", e, c);
  endtask
  task automatic qry(input int cd);
    i_qry_code = 16'(cd);
    tick();
    chk_b("qry_en", flt[cd + 512], qry_en);
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 1024; i++) flt[i] = (i - 512) < 100;
    repeat (8) @(posedge i_clk);
    #10;
    i_rstn = 1'b1;
    chk_v("count", 16'h0000, 16'(count));
    pop(1'b0);
    qry(-512);
    qry(99);
    qry(100);
    done("reset");
    // Random errors and status codes past capacity, drained on both branches
    for (int k = 0; k < 18; k++) msg(k % 3 == 0 ? 100 + rnd(400) : -1 - rnd(500));
    chk_v("count", 16'h000A, 16'(count));
    for (int k = 0; k < 11; k++) pop(k[0]);
    done("overflow");
    // Enable list of a reversed range and singles, then a disable list
    hc(eqf_pkg::CMD_ENA_START, 0, 0);
    rng(-512, 511, 0);
    hc(eqf_pkg::CMD_ENA_ADD, -110, -222);
    hc(eqf_pkg::CMD_ENA_ADD, -230, -230);
    hc(eqf_pkg::CMD_ENA_ADD, 150, 150);
    rng(-222, -110, 1);
    rng(-230, -230, 1);
    rng(150, 150, 1);
    foreach (pts[i]) qry(pts[i]);
    foreach (pts[i]) msg(pts[i]);
    hc(eqf_pkg::CMD_DIS_ADD, -110, -110);
    rng(-110, -110, 0);
    qry(-110);
    repeat (4) pop(1'b1);
    msg(-110);
    done("filter");
    // Empty enable list blocks everything
    hc(eqf_pkg::CMD_ENA_START, 0, 0);
    rng(-512, 511, 0);
    msg(-5);
    qry(-150);
    done("empty list");
    // Clear discards held entries
    hc(eqf_pkg::CMD_ENA_START, 0, 0);
    hc(eqf_pkg::CMD_ENA_ADD, -512, 511);
    rng(-512, 511, 1);
    repeat (3) msg(-1 - rnd(500));
    hc(eqf_pkg::CMD_CLEAR, 0, 0);
    q.delete();
    chk_v("count", 16'h0000, 16'(count));
    pop(1'b0);
    done("clear");
    // Preset zeroes the enable registers and leaves the queue
    for (int s = 0; s < 3; s++) begin
      ed[s] = 16'(rnd(65536));
      i_eqf_host.cmd(eqf_pkg::CMD_WR_ENA, 0, 0, eqf_pkg::eqf_ena_sel_t'(s), ed[s]);
    end
    chk_v("meas", ed[0], ena.meas);
    chk_v("ques", ed[1], ena.ques);
    chk_v("oper", ed[2], ena.oper);
    msg(-7);
    msg(-8);
    hc(eqf_pkg::CMD_PRESET, 0, 0);
    chk_v("meas", 16'h0000, ena.meas);
    chk_v("ques", 16'h0000, ena.ques);
    chk_v("oper", 16'h0000, ena.oper);
    chk_v("count", 16'h0002, 16'(count));
    pop(1'b0);
    done("preset");
    report_and_stop();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    report_and_stop();
  end
endmodule // test_error_queue_with_filter
`default_nettype wire
